// [common/hwg_cfg.svh]
// Offsets, fields, resets and timing of the haptic waveform generator
// Operation
// - Mixer whose source select holds 0x06 receives the haptic output.
// - Generator runs at the rate chosen by its rate field.
// - One select bit chooses rotating-mass or resonant output shaping.
// - Resonance divider is used only with the resonant actuator.
// - Mode bits 3:2: 00 off, 01 continuous, 10 one-shot, 11 reserved.
// - Writing trigger bit 4 in one-shot mode runs phases 1, 2, 3.
// - Each phase has its own duration and signed intensity.
// - Continuous mode uses only the middle step level.
// - Rotating-mass output is a DC level equal to the intensity.
// - Resonant output is AC; negative intensity inverts phase 180 degrees.
// - Phases count 0.625 ms steps, 9/11/9 bits; zero lasts no time (the code holds a zero-length phase for one clock cycle).
// - Each 8-bit intensity is two's complement, plus to minus full scale.
// - Half period is divider+1 base ticks; base clock chosen by rate.
// - Status bit 0 reads 1 while a one-shot profile runs.
`ifndef HWG_CFG_SVH
`define HWG_CFG_SVH
`define HWG_OFS_CTRL1    16'h0090
`define HWG_OFS_FREQ     16'h0091
`define HWG_OFS_P1_LVL   16'h0092
`define HWG_OFS_P1_LEN   16'h0093
`define HWG_OFS_P2_LVL   16'h0094
`define HWG_OFS_P2_LEN   16'h0095
`define HWG_OFS_P3_LVL   16'h0096
`define HWG_OFS_P3_LEN   16'h0097
`define HWG_OFS_STATUS   16'h0098
`define HWG_BIT_TRIG     4
`define HWG_BIT_ACT      1
`define HWG_MODE_HI      3
`define HWG_MODE_LO      2
`define HWG_RATE_HI      14
`define HWG_RATE_LO      11
`define HWG_MODE_OFF     2'h0
`define HWG_MODE_CONT    2'h1
`define HWG_MODE_SHOT    2'h2
`define HWG_FREQ_RST     15'h7fff
`define HWG_MIX_SRC      8'h06
`define HWG_STEP_PS      625000000
`define HWG_CLK_PS       5000
`define HWG_STEP_CYCLES  (`HWG_STEP_PS / `HWG_CLK_PS)
`endif

// [common/hwg_pkg.sv]
// Types of the haptic waveform generator
package hwg_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_P1, ST_P2, ST_P3} hwg_state_t;

   typedef struct packed {
      logic [3:0]  rate;
      logic [1:0]  mode;
      logic        act;
      logic [14:0] freq;
      logic [7:0]  p1_lvl;
      logic [8:0]  p1_len;
      logic [7:0]  p2_lvl;
      logic [10:0] p2_len;
      logic [7:0]  p3_lvl;
      logic [8:0]  p3_len;
   } hwg_regs_t;
endpackage

// [core/hwg_top.sv]
// Haptic waveform generator with its output FIFO
`timescale 1ns/100ps
`include "hwg_cfg.svh"

// ==========================================
// Sample FIFO
module hwg_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic             push;
   logic             pop;

   assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
   assign out_valid = wr_ptr != rd_ptr;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule

// ==========================================
// Generator
module hwg_top #(
   parameter int STEP_CYCLES = `HWG_STEP_CYCLES,
   parameter int FIFO_DEPTH  = 16
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic        sys_base_tick,
   input  wire logic        async_base_tick,
   input  wire logic        sys_sample_tick,
   input  wire logic        async_sample_tick,
   input  wire logic [7:0]  mixer_input_select,
   output logic             mix_valid,
   input  wire logic        mix_ready,
   output logic      [23:0] mix_data
);
   // Level scaled to 24 bits, optionally negated with saturation
   function automatic logic [23:0] hwg_level(input logic [7:0] lvl, input logic inv);
      logic [23:0] v;
      v = {lvl, 16'h0000};
      if (!inv)
      begin
         return v;
      end
      if (v == 24'h800000)
      begin
         return 24'h7fffff;
      end
      return 24'h000000 - v;
   endfunction

   hwg_pkg::hwg_regs_t  regs;
   hwg_pkg::hwg_state_t state;
   logic [10:0] left;
   logic [31:0] step_cnt;
   logic        step_tick;
   logic [14:0] wave_cnt;
   logic        pol;
   logic        trig_wr;
   logic        ctrl_wr;
   logic        busy;
   logic        base_tick;
   logic        samp_tick;
   logic [7:0]  cur_lvl;
   logic        live;
   logic [23:0] sample;
   logic        gen_ready;
   logic        fifo_valid;
   logic        sel_hit;

   // ==========================================
   // Register writes
   assign ctrl_wr = reg_wr && reg_addr == `HWG_OFS_CTRL1;
   assign trig_wr = ctrl_wr && reg_wdata[`HWG_BIT_TRIG]
                    && reg_wdata[`HWG_MODE_HI:`HWG_MODE_LO] == `HWG_MODE_SHOT;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         regs      <= '0;
         regs.freq <= `HWG_FREQ_RST;
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            `HWG_OFS_CTRL1:
            begin
               regs.rate <= reg_wdata[`HWG_RATE_HI:`HWG_RATE_LO];
               regs.mode <= reg_wdata[`HWG_MODE_HI:`HWG_MODE_LO];
               regs.act  <= reg_wdata[`HWG_BIT_ACT];
            end
            `HWG_OFS_FREQ:   regs.freq   <= reg_wdata[14:0];
            `HWG_OFS_P1_LVL: regs.p1_lvl <= reg_wdata[7:0];
            `HWG_OFS_P1_LEN: regs.p1_len <= reg_wdata[8:0];
            `HWG_OFS_P2_LVL: regs.p2_lvl <= reg_wdata[7:0];
            `HWG_OFS_P2_LEN: regs.p2_len <= reg_wdata[10:0];
            `HWG_OFS_P3_LVL: regs.p3_lvl <= reg_wdata[7:0];
            `HWG_OFS_P3_LEN: regs.p3_len <= reg_wdata[8:0];
            default:;
         endcase
      end
   end

   // ==========================================
   // Register reads, one cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         reg_rdata <= '0;
      end
      else if (reg_rd)
      begin
         unique case (reg_addr)
            `HWG_OFS_CTRL1:  reg_rdata <= {1'b0, regs.rate, 6'h00, 1'b0,
                                           regs.mode, regs.act, 1'b0};
            `HWG_OFS_FREQ:   reg_rdata <= {1'b0, regs.freq};
            `HWG_OFS_P1_LVL: reg_rdata <= {8'h00, regs.p1_lvl};
            `HWG_OFS_P1_LEN: reg_rdata <= {7'h00, regs.p1_len};
            `HWG_OFS_P2_LVL: reg_rdata <= {8'h00, regs.p2_lvl};
            `HWG_OFS_P2_LEN: reg_rdata <= {5'h00, regs.p2_len};
            `HWG_OFS_P3_LVL: reg_rdata <= {8'h00, regs.p3_lvl};
            `HWG_OFS_P3_LEN: reg_rdata <= {7'h00, regs.p3_len};
            `HWG_OFS_STATUS: reg_rdata <= {15'h0000, busy};
            default:         reg_rdata <= '0;
         endcase
      end
   end

   // ==========================================
   // Rate and base clock selection
   // rate picks clock source
   assign base_tick = regs.rate[3] ? async_base_tick : sys_base_tick;
   assign samp_tick = regs.rate[3] ? async_sample_tick : sys_sample_tick;

   // ==========================================
   // Phase step timer
   assign step_tick = step_cnt == 32'(STEP_CYCLES - 1);

   always_ff @(posedge clk)
   begin
      if (!rst_n || trig_wr || state == hwg_pkg::ST_IDLE || step_tick)
      begin
         step_cnt <= '0;
      end
      else
      begin
         step_cnt <= step_cnt + 32'd1;
      end
   end

   // ==========================================
   // One-shot sequencer
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state <= hwg_pkg::ST_IDLE;
         left  <= '0;
      end
      else if (regs.mode != `HWG_MODE_SHOT && !trig_wr)
      begin
         state <= hwg_pkg::ST_IDLE;
      end
      else if (trig_wr)
      begin
         state <= hwg_pkg::ST_P1;
         left  <= {2'b00, regs.p1_len};
      end
      else
      begin
         unique case (state)
            hwg_pkg::ST_IDLE:;
            hwg_pkg::ST_P1:
            if (left == '0)
            begin
               state <= hwg_pkg::ST_P2;
               left  <= regs.p2_len;
            end
            hwg_pkg::ST_P2:
            if (left == '0)
            begin
               state <= hwg_pkg::ST_P3;
               left  <= {2'b00, regs.p3_len};
            end
            hwg_pkg::ST_P3:
            if (left == '0)
            begin
               state <= hwg_pkg::ST_IDLE;
            end
         endcase
         if (left != '0 && step_tick)
         begin
            left <= left - 11'd1;
         end
      end
   end

   assign busy = state != hwg_pkg::ST_IDLE;

   // ==========================================
   // Resonant half-period divider
   always_ff @(posedge clk)
   begin
      if (!rst_n || !regs.act)
      begin
         wave_cnt <= '0;
         pol      <= 1'b0;
      end
      else if (base_tick)
      begin
         if (wave_cnt >= regs.freq)
         begin
            wave_cnt <= '0;
            pol      <= ~pol;
         end
         else
         begin
            wave_cnt <= wave_cnt + 15'd1;
         end
      end
   end

   // ==========================================
   // Sample shaping
   always_comb
   begin
      cur_lvl = regs.p2_lvl;
      live    = 1'b0;
      if (regs.mode == `HWG_MODE_CONT)
      begin
         live = 1'b1;
      end
      else if (regs.mode == `HWG_MODE_SHOT)
      begin
         live = busy;
         unique case (state)
            hwg_pkg::ST_P1:   cur_lvl = regs.p1_lvl;
            hwg_pkg::ST_P3:   cur_lvl = regs.p3_lvl;
            default:          cur_lvl = regs.p2_lvl;
         endcase
      end
      sample = live ? hwg_level(cur_lvl, regs.act && pol) : 24'h000000;
   end

   // ==========================================
   // Output FIFO and mixer port
   // only a matching source select drains
   assign sel_hit   = mixer_input_select == `HWG_MIX_SRC;
   assign mix_valid = fifo_valid && sel_hit;

   hwg_fifo #(
      .WIDTH (24),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (samp_tick),
      .in_ready  (gen_ready),
      .in_data   (sample),
      .out_valid (fifo_valid),
      .out_ready (mix_ready && sel_hit),
      .out_data  (mix_data)
   );

   // ==========================================
   // Checks
   property p_sel;
      @(posedge clk) disable iff (!rst_n) mix_valid |-> mixer_input_select == 8'h06;
   endproperty
   a_sel: assert property (p_sel) else $error("valid without source 6");

   property p_rate;
      @(posedge clk) disable iff (!rst_n)
      !(regs.rate[3] ? async_sample_tick : sys_sample_tick) |=> $stable(u_fifo.wr_ptr);
   endproperty
   a_rate: assert property (p_rate) else $error("sample off rate");

   property p_off;
      @(posedge clk) disable iff (!rst_n)
      (regs.mode == 2'h0 && !reg_wr) |=> state == hwg_pkg::ST_IDLE;
   endproperty
   a_off: assert property (p_off) else $error("disabled but running");

   property p_trig;
      @(posedge clk) disable iff (!rst_n) trig_wr |=> state == hwg_pkg::ST_P1;
   endproperty
   a_trig: assert property (p_trig) else $error("trigger missed");

   property p_ignore;
      @(posedge clk) disable iff (!rst_n)
      (ctrl_wr && reg_wdata[4] && reg_wdata[3:2] != 2'h2 && !busy) |=> !busy;
   endproperty
   a_ignore: assert property (p_ignore) else $error("trigger not ignored");

   property p_status;
      @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == 16'h0098) |=> reg_rdata[0] == $past(busy);
   endproperty
   a_status: assert property (p_status) else $error("status mismatch");

   property p_cont;
      @(posedge clk) disable iff (!rst_n)
      (regs.mode == 2'h1 && !regs.act) |-> sample == {regs.p2_lvl, 16'h0000};
   endproperty
   a_cont: assert property (p_cont) else $error("continuous level wrong");

   property p_zero;
      @(posedge clk) disable iff (!rst_n)
      (state == hwg_pkg::ST_P3 && left == '0 && !ctrl_wr && regs.mode == 2'h2)
      |=> !busy && sample == 24'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("output after phase 3");

   property p_shot_end;
      @(posedge clk) disable iff (!rst_n) busy ##1 !busy;
   endproperty
   c_shot_end: cover property (p_shot_end);

   property p_full;
      @(posedge clk) disable iff (!rst_n) !gen_ready;
   endproperty
   c_full: cover property (p_full);

   property p_ac_flip;
      @(posedge clk) disable iff (!rst_n) regs.act && $changed(pol) && live;
   endproperty
   c_ac_flip: cover property (p_ac_flip);
endmodule

// [verification/hwg_mix_model.sv]
// Output mixer model draining the haptic sample stream
`timescale 1ns/100ps
// ==========
// Mixer
module hwg_mix_model (
   input  wire logic        clk,
   input  wire logic        stall,
   input  wire logic        mix_valid,
   input  wire logic [23:0] mix_data,
   output logic             mix_ready = 1'b0,
   output logic             took = 1'b0,
   output logic      [23:0] took_data = 24'h0
);
   // Ready drops a cycle after a stall request
   always @(posedge clk)
   begin
      mix_ready <= !stall;
      took      <= mix_valid && mix_ready;
      took_data <= mix_data;
   end
endmodule

// [verification/test_haptic_waveform_generator.sv]
// Self-checking bench of the haptic waveform generator
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
$display("Error t=%0t got %h exp %h", $time, a, e); end end
module test_haptic_waveform_generator;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        stall = 1'b0;
   logic [15:0] reg_addr = 16'h0;
   logic [15:0] reg_wdata = 16'h0;
   logic [15:0] reg_rdata;
   logic [15:0] rd_val;
   logic [7:0]  sel = 8'h06;
   logic        sb = 1'b0;
   logic        ab = 1'b0;
   logic        ss = 1'b0;
   logic        as_t = 1'b0;
   logic        sys_on = 1'b1;
   logic        async_on = 1'b0;
   logic [1:0]  cnt = 2'h0;
   logic        mix_valid;
   logic        mix_ready;
   logic        took;
   logic [23:0] mix_data;
   logic [23:0] took_data;
   logic [23:0] last = 24'h0;
   logic [23:0] q[$];
   int          n_errors = 0;
   int          samples_checked = 0;
   int          n_pop = 0;
   int          cycles = 0;
   int          p;

   initial forever #2.5 clk = ~clk;

   hwg_top #(.STEP_CYCLES(4), .FIFO_DEPTH(16)) dut (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sys_base_tick(sb), .async_base_tick(ab), .sys_sample_tick(ss),
      .async_sample_tick(as_t), .mixer_input_select(sel),
      .mix_valid(mix_valid), .mix_ready(mix_ready), .mix_data(mix_data));

   hwg_mix_model mix (.clk(clk), .stall(stall), .mix_valid(mix_valid),
      .mix_data(mix_data), .mix_ready(mix_ready), .took(took), .took_data(took_data));

   // ==========
   // Ticks, sample log and timeout
   always @(posedge clk)
   begin
      cnt  <= cnt + 2'h1;
      sb   <= cnt[0];
      ab   <= !cnt[0];
      ss   <= sys_on && cnt[0];
      as_t <= async_on && cnt[0];
   end

   // Log each change of the popped sample value
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (took)
         n_pop <= n_pop + 1;
      if (took && took_data !== last)
      begin
         q.push_back(took_data);
         last <= took_data;
      end
      if (cycles == 20000)
      begin
         n_errors++;
         final_report();
      end
   end

   // ==========
   // Tasks
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      rd_val = reg_rdata;
   endtask

   task automatic final_report;
      $display("Checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ==========
   // Scenarios
   task automatic t_regs;
      rd(16'h0090); `CHK(rd_val, 16'h0000)
      rd(16'h0091); `CHK(rd_val, 16'h7fff)
      rd(16'h00a0); `CHK(rd_val, 16'h0000)
      wr(16'h0090, 16'h781e);
      rd(16'h0090); `CHK(rd_val, 16'h780e)
      wr(16'h0095, 16'hffff);
      rd(16'h0095); `CHK(rd_val, 16'h07ff)
      wr(16'h0098, 16'h0001);
      rd(16'h0098); `CHK(rd_val, 16'h0000)
   endtask

   task automatic t_refuse;
      wr(16'h0090, 16'h0014);
      rd(16'h0098); `CHK(rd_val, 16'h0000)
      wr(16'h0090, 16'h001c);
      rd(16'h0098); `CHK(rd_val, 16'h0000)
      wr(16'h0090, 16'h0010);
      rd(16'h0098); `CHK(rd_val, 16'h0000)
   endtask

   task automatic t_shot;
      wr(16'h0092, 16'h0040);
      wr(16'h0093, 16'h0003);
      wr(16'h0094, 16'h007f);
      wr(16'h0095, 16'h0002);
      wr(16'h0096, 16'h00c0);
      wr(16'h0097, 16'h0003);
      wt(10);
      q.delete();
      wr(16'h0090, 16'h0018);
      wt(26);
      rd(16'h0098); `CHK(rd_val, 16'h0001)
      wt(12);
      rd(16'h0098); `CHK(rd_val, 16'h0000)
      wt(10);
      `CHK(q.size(), 4)
      `CHK(q[0], 24'h400000)
      `CHK(q[1], 24'h7f0000)
      `CHK(q[2], 24'hc00000)
      `CHK(q[3], 24'h000000)
   endtask

   task automatic t_zero;
      wr(16'h0093, 16'h0000);
      wr(16'h0095, 16'h0000);
      wr(16'h0097, 16'h0000);
      wr(16'h0090, 16'h0018);
      wt(4);
      rd(16'h0098); `CHK(rd_val, 16'h0000)
   endtask

   task automatic t_abort;
      wr(16'h0093, 16'h01ff);
      wr(16'h0090, 16'h0018);
      wt(5);
      rd(16'h0098); `CHK(rd_val, 16'h0001)
      wr(16'h0090, 16'h0000);
      rd(16'h0098); `CHK(rd_val, 16'h0000)
      wt(20);
      `CHK(last, 24'h000000)
   endtask

   task automatic t_cont;
      wr(16'h0091, 16'h0001);
      wr(16'h0092, 16'h0011);
      wr(16'h0094, 16'h0085);
      wr(16'h0096, 16'h0022);
      wr(16'h0090, 16'h0004);
      wt(20);
      q.delete();
      wt(20);
      `CHK(q.size(), 0)
      `CHK(last, 24'h850000)
      wr(16'h0094, 16'h0040);
      wr(16'h0090, 16'h0006);
      wt(20);
      q.delete();
      wt(30);
      `CHK(q[1] + q[2], 24'h000000)
      `CHK(q[2][22:0], 23'h400000)
      wr(16'h0094, 16'h00c0);
      wt(20);
      q.delete();
      wt(30);
      `CHK(q[1] + q[2], 24'h000000)
      `CHK(q[1] | q[2], 24'hc00000)
   endtask

   task automatic t_rate;
      sys_on   <= 1'b0;
      async_on <= 1'b1;
      wr(16'h0090, 16'h0004);
      wt(20);
      p = n_pop;
      wt(20);
      `CHK(n_pop - p, 0)
      wr(16'h0090, 16'h4004);
      wt(20);
      `CHK(n_pop > p, 1'b1)
      sys_on   <= 1'b1;
      async_on <= 1'b0;
   endtask

   task automatic t_fifo;
      wr(16'h0090, 16'h0004);
      stall <= 1'b1;
      wt(60);
      sel <= 8'h05;
      @(negedge clk);
      `CHK(mix_valid, 1'b0)
      @(posedge clk);
      sel <= 8'h06;
      @(negedge clk);
      `CHK(mix_valid, 1'b1)
      sys_on <= 1'b0;
      p = n_pop;
      stall <= 1'b0;
      wt(40);
      `CHK(n_pop - p, 16)
      sys_on <= 1'b1;
   endtask

   initial
   begin
      wt(8);
      rst_n <= 1'b1;
      t_regs();
      t_refuse();
      t_shot();
      t_zero();
      t_abort();
      t_cont();
      t_rate();
      t_fifo();
      final_report();
   end
endmodule
